//--- rtl/rtccfg_pkg.sv
// Purpose: Shared constants of the clock-calendar configuration block.
// Assumes: One 200 MHz clock; 32.768 kHz source arrives on a pin.
// Notes: Register offsets are word indices on the plain register port.
package rtccfg_pkg;

    // Register port offsets.
    localparam logic [1:0] ADDR_CFG = 2'h0;
    localparam logic [1:0] ADDR_WIN_HIGH = 2'h1;
    localparam logic [1:0] ADDR_WIN_LOW = 2'h2;

    // Field positions inside the configuration register.
    localparam int EN_BIT = 15;
    localparam int RSVD_BIT = 14;
    localparam int UNLOCK_BIT = 13;
    localparam int SYNC_BIT = 12;
    localparam int HALF_BIT = 11;
    localparam int OE_BIT = 10;
    localparam int PTR_MSB = 9;
    localparam int PTR_LSB = 8;
    localparam int CAL_MSB = 7;

    // Values after power-on reset.
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] DAY_RESET = 8'h01;
    localparam logic [7:0] MON_RESET = 8'h01;

    // Window pointer codes.
    localparam logic [1:0] PTR_MINUTES_SECONDS_REG = 2'h0;
    localparam logic [1:0] PTR_WDAYHR = 2'h1;
    localparam logic [1:0] PTR_MONDAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;

    // Rollover limits in BCD.
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] HR_LAST = 8'h23;
    localparam logic [7:0] WDAY_LAST = 8'h06;
    localparam logic [7:0] MON_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;

    // Prescaler and calibration counts.
    localparam int PRE_BITS = 15;
    localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3b;
    localparam int CAL_SHIFT = 2;
    localparam int SYNC_LEAD = 32;

endpackage

//--- rtl/rtccfg_sync.sv
// Purpose: Brings the slow source clock pin into the main clock domain.
// Assumes: The source is far slower than mclk_in.
// Notes: Emits one pulse per rising edge of the source.
module rtccfg_sync (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Pin and pulse.
    input wire logic src_in,
    output logic rise_out
);

    logic meta_q;
    logic stable_q;
    logic last_q;

    // Two flops before anything looks at the pin; the third remembers.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= 1'b0;
            stable_q <= 1'b0;
            last_q <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            meta_q <= src_in;
            stable_q <= meta_q;
            last_q <= stable_q;
            rise_out <= stable_q & ~last_q;
        end
    end

endmodule

//--- rtl/rtccfg_tick.sv
// Purpose: Calibrated prescaler giving the half-second phase and ticks.
// Assumes: One source pulse per 32.768 kHz edge.
// Notes: Calibration is applied once per minute, spread over pulses.
module rtccfg_tick #(
    parameter int PRE_BITS = rtccfg_pkg::PRE_BITS
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Control.
    input wire logic en_in,
    input wire logic src_pulse_in,
    input wire logic clr_in,
    input wire logic [7:0] cal_in,
    // Status.
    output logic half_out,
    output logic sec_tick_out,
    output logic near_out
);

    localparam logic [PRE_BITS-1:0] NEAR_AT =
        PRE_BITS'((1 << PRE_BITS) - rtccfg_pkg::SYNC_LEAD);

    logic [PRE_BITS-1:0] sub_q;
    logic [5:0] min_cnt_q;
    logic [9:0] adj_q;
    logic adj_pos_q;

    // A positive adjustment counts a pulse twice, a negative one skips it.
    wire adj_act = (adj_q != 10'h000);
    wire [1:0] step = !src_pulse_in ? 2'h0 :
                      (adj_act && adj_pos_q) ? 2'h2 :
                      adj_act ? 2'h0 : 2'h1;
    wire [PRE_BITS:0] sum = {1'b0, sub_q} + {{(PRE_BITS - 1){1'b0}}, step};
    wire wrap = sum[PRE_BITS];
    wire [7:0] cal_mag = cal_in[7] ? 8'(-cal_in) : cal_in;
    wire min_end = (min_cnt_q == rtccfg_pkg::SEC_PER_MIN_LAST);

    // Prescaler, minute count and pending calibration pulses.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sub_q <= '0;
            min_cnt_q <= 6'h00;
            adj_q <= 10'h000;
            adj_pos_q <= 1'b0;
            sec_tick_out <= 1'b0;
            near_out <= 1'b0;
        end else begin
            sec_tick_out <= en_in & wrap & ~clr_in;
            near_out <= en_in & (sub_q >= NEAR_AT);
            if (clr_in) begin
                sub_q <= '0;
            end else if (en_in) begin
                sub_q <= sum[PRE_BITS-1:0];
                if (src_pulse_in && adj_act) begin
                    adj_q <= adj_q - 10'h001;
                end
                if (wrap && min_end) begin
                    min_cnt_q <= 6'h00;
                    adj_q <= 10'({2'b00, cal_mag} <<
                                 rtccfg_pkg::CAL_SHIFT);
                    adj_pos_q <= ~cal_in[7];
                end else if (wrap) begin
                    min_cnt_q <= min_cnt_q + 6'h01;
                end
            end
        end
    end

    // The top prescaler bit is high through the second half of a second.
    assign half_out = sub_q[PRE_BITS-1];

endmodule

//--- rtl/rtccfg_top.sv
// Purpose: Configuration and calibration register of a clock-calendar.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Power-on reset is the only reset this register sees.
//
// Local design decisions: the strobed register port and the register offsets.
module rtccfg_top (
    // Clock and power-on reset.
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Register port.
    input wire logic [1:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rd_data_out,
    // Oscillator source pin.
    input wire logic src_clk_in,
    // Module status and clock output pin.
    output logic module_enable_out,
    output logic clock_out
);

    // Configuration fields, read data and clock pin flops.
    logic clock_module_enable_q;
    logic time_write_unlock_q;
    logic clock_output_enable_q;
    logic [1:0] time_window_pointer_q;
    logic [7:0] calibration_q;
    logic [15:0] rd_data_q;
    logic clock_out_q;

    // Time of day and calendar, all in BCD.
    logic [7:0] sec_q;
    logic [7:0] min_q;
    logic [7:0] hr_q;
    logic [7:0] wday_q;
    logic [7:0] day_q;
    logic [7:0] mon_q;
    logic [7:0] yr_q;

    // Outputs of the synchroniser and the prescaler.
    logic src_rise;
    logic half_second_status;
    logic sec_tick;
    logic read_sync_status;

    // Steps a BCD byte by one.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} :
                               {v[7:4], 4'(v[3:0] + 4'h1)};
        return r;
    endfunction

    // Steps a BCD byte, wrapping from its last value to its first.
    function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                            input logic [7:0] last,
                                            input logic [7:0] first);
        logic [7:0] r;
        r = (v == last) ? first : bcd_inc(v);
        return r;
    endfunction

    // Register port decode. Index 0 is the configuration image, 1 and 2
    // are the high and low bytes of the time window, and 3 is unmapped:
    // writes to it fall through every decode below and reads return zero.
    // The port never stalls, so every strobe is acted on in its own cycle.
    wire cfg_wr = wr_in && (addr_in == rtccfg_pkg::ADDR_CFG);
    wire hi_acc = (wr_in || rd_in) && (addr_in == rtccfg_pkg::ADDR_WIN_HIGH);
    wire hi_wr = wr_in && (addr_in == rtccfg_pkg::ADDR_WIN_HIGH);
    wire lo_wr = wr_in && (addr_in == rtccfg_pkg::ADDR_WIN_LOW);
    wire [7:0] wbyte = wr_data_in[7:0];

    // Window writes land only while unlocked; the pointer picks the field.
    // A locked write is dropped here rather than later, so neither a field nor
    // the half-second restart sees it; a locked high-byte write still steps the pointer.
    wire hi_ok = hi_wr && time_write_unlock_q;
    wire lo_ok = lo_wr && time_write_unlock_q;
    wire ptr_ms = (time_window_pointer_q == rtccfg_pkg::PTR_MINUTES_SECONDS_REG);
    wire ptr_wh = (time_window_pointer_q == rtccfg_pkg::PTR_WDAYHR);
    wire ptr_md = (time_window_pointer_q == rtccfg_pkg::PTR_MONDAY);
    wire ptr_yr = (time_window_pointer_q == rtccfg_pkg::PTR_YEAR);
    wire wr_min = hi_ok && ptr_ms;
    wire wr_wday = hi_ok && ptr_wh;
    wire wr_mon = hi_ok && ptr_md;
    wire wr_sec = lo_ok && ptr_ms;
    wire wr_hr = lo_ok && ptr_wh;
    wire wr_day = lo_ok && ptr_md;
    wire wr_yr = lo_ok && ptr_yr;

    // Days in the current month, with leap years in BCD. Only the two
    // year digits are kept, so every year divisible by four counts as a
    // leap year; that is right for the years 2000 to 2099 and no further.
    wire yr_leap = yr_q[4] ? (yr_q[3:0] == 4'h2 || yr_q[3:0] == 4'h6) :
                   (yr_q[3:0] == 4'h0 || yr_q[3:0] == 4'h4 ||
                    yr_q[3:0] == 4'h8);
    wire mon_short = (mon_q == 8'h04) || (mon_q == 8'h06) ||
                     (mon_q == 8'h09) || (mon_q == 8'h11);
    wire [7:0] day_last = (mon_q == 8'h02) ? (yr_leap ? 8'h29 : 8'h28) :
                          mon_short ? 8'h30 : 8'h31;

    // Carry chain from seconds up to years, all resolved in one cycle.
    // Because every field moves on the same edge, a reader can only see a
    // torn value across two separate reads, which the status bit warns of.
    wire c_min = sec_tick && (sec_q == rtccfg_pkg::SEC_LAST);
    wire c_hr = c_min && (min_q == rtccfg_pkg::SEC_LAST);
    wire c_day = c_hr && (hr_q == rtccfg_pkg::HR_LAST);
    wire c_mon = c_day && (day_q == day_last);
    wire c_yr = c_mon && (mon_q == rtccfg_pkg::MON_LAST);

    // Next values; a software write to a field wins over a tick.
    // A write to one field still lets a pending carry reach the next one.
    wire [7:0] sec_d = wr_sec ? wbyte :
        sec_tick ? bcd_next(sec_q, rtccfg_pkg::SEC_LAST, 8'h00) : sec_q;
    wire [7:0] min_d = wr_min ? wbyte :
        c_min ? bcd_next(min_q, rtccfg_pkg::SEC_LAST, 8'h00) : min_q;
    wire [7:0] hr_d = wr_hr ? wbyte :
        c_hr ? bcd_next(hr_q, rtccfg_pkg::HR_LAST, 8'h00) : hr_q;
    wire [7:0] wday_d = wr_wday ? wbyte :
        c_day ? bcd_next(wday_q, rtccfg_pkg::WDAY_LAST, 8'h00) : wday_q;
    wire [7:0] day_d = wr_day ? wbyte :
        c_day ? bcd_next(day_q, day_last, 8'h01) : day_q;
    wire [7:0] mon_d = wr_mon ? wbyte :
        c_mon ? bcd_next(mon_q, rtccfg_pkg::MON_LAST, 8'h01) : mon_q;
    wire [7:0] yr_d = wr_yr ? wbyte :
        c_yr ? bcd_next(yr_q, rtccfg_pkg::YEAR_LAST, 8'h00) : yr_q;

    // Window contents chosen by the pointer; the high byte of 11 is zero.
    // Reading a field never changes it; only the pointer moves on a read.
    wire [7:0] win_high = ptr_ms ? min_q : ptr_wh ? wday_q :
                          ptr_md ? mon_q : 8'h00;
    wire [7:0] win_low = ptr_ms ? sec_q : ptr_wh ? hr_q :
                         ptr_md ? day_q : yr_q;

    // Configuration image; bit 14 has no storage and reads zero.
    // Bits 12 and 11 come from the prescaler, so writes cannot reach them.
    wire [15:0] cfg_image = {clock_module_enable_q, 1'b0,
                             time_write_unlock_q, read_sync_status,
                             half_second_status, clock_output_enable_q,
                             time_window_pointer_q, calibration_q};
    wire [15:0] rd_mux = (addr_in == rtccfg_pkg::ADDR_CFG) ? cfg_image :
        (addr_in == rtccfg_pkg::ADDR_WIN_HIGH) ? {8'h00, win_high} :
        (addr_in == rtccfg_pkg::ADDR_WIN_LOW) ? {8'h00, win_low} :
        16'h0000;

    // The pointer steps down on any high-byte access, lock or not. It
    // saturates at 00, so a long run of high-byte reads keeps showing the
    // minutes and seconds pair until software loads a new pointer.
    wire ptr_step = hi_acc && !ptr_ms;
    wire [1:0] ptr_wr = wr_data_in[rtccfg_pkg::PTR_MSB:rtccfg_pkg::PTR_LSB];
    wire [1:0] ptr_d = cfg_wr ? ptr_wr :
                       ptr_step ? 2'(time_window_pointer_q - 2'h1) :
                       time_window_pointer_q;

    // Writing the seconds byte restarts the second, clearing bit 11.
    // A locked write changes nothing, so it leaves the second running.
    wire clr_half = wr_sec;

    // Only the enable flop gates the prescaler, so time stops when off.
    // Window writes still land while stopped, which is how time is set.
    wire run = clock_module_enable_q;

    // Source pin synchroniser; nothing else reads the raw pin.
    rtccfg_sync rtccfg_sync_inst (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .src_in(src_clk_in),
        .rise_out(src_rise)
    );

    // Calibrated prescaler giving the half-second phase and second ticks.
    rtccfg_tick #(
        .PRE_BITS(rtccfg_pkg::PRE_BITS)
    ) rtccfg_tick_inst (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .en_in(run),
        .src_pulse_in(src_rise),
        .clr_in(clr_half),
        .cal_in(calibration_q),
        .half_out(half_second_status),
        .sec_tick_out(sec_tick),
        .near_out(read_sync_status)
    );

    // The enable bit follows a write only if the unlock bit was already
    // set before it; one write cannot both unlock and flip the enable,
    // which keeps a single stray store from starting or stopping time.
    wire en_wr = cfg_wr && time_write_unlock_q;

    // Enable bit; cleared by the power-on reset, loaded by a write while unlocked.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_module_enable_q <= rtccfg_pkg::CFG_RESET[15];
        end else if (en_wr) begin
            clock_module_enable_q <= wr_data_in[rtccfg_pkg::EN_BIT];
        end
    end

    // Unlock bit; written directly, with no key sequence in front of it.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            time_write_unlock_q <= rtccfg_pkg::CFG_RESET[13];
        end else if (cfg_wr) begin
            time_write_unlock_q <= wr_data_in[rtccfg_pkg::UNLOCK_BIT];
        end
    end

    // Output enable bit for the clock pin.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_output_enable_q <= rtccfg_pkg::CFG_RESET[10];
        end else if (cfg_wr) begin
            clock_output_enable_q <= wr_data_in[rtccfg_pkg::OE_BIT];
        end
    end

    // Window pointer; loaded by a write, stepped by high-byte accesses.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            time_window_pointer_q <= rtccfg_pkg::CFG_RESET[9:8];
        end else begin
            time_window_pointer_q <= ptr_d;
        end
    end

    // Calibration byte; the prescaler picks it up at the next minute end.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            calibration_q <= rtccfg_pkg::CFG_RESET[7:0];
        end else if (cfg_wr) begin
            calibration_q <= wr_data_in[rtccfg_pkg::CAL_MSB:0];
        end
    end

    // Time of day; each field takes its next value on every clock.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec_q <= rtccfg_pkg::SEC_RESET;
            min_q <= rtccfg_pkg::SEC_RESET;
            hr_q <= rtccfg_pkg::SEC_RESET;
        end else begin
            sec_q <= sec_d;
            min_q <= min_d;
            hr_q <= hr_d;
        end
    end

    // Calendar; it starts on day 01 of month 01 after power-on reset.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wday_q <= rtccfg_pkg::SEC_RESET;
            day_q <= rtccfg_pkg::DAY_RESET;
            mon_q <= rtccfg_pkg::MON_RESET;
            yr_q <= rtccfg_pkg::SEC_RESET;
        end else begin
            wday_q <= wday_d;
            day_q <= day_d;
            mon_q <= mon_d;
            yr_q <= yr_d;
        end
    end

    // Read data stands for exactly the cycle after the strobe.
    // Returning zero outside that cycle keeps a shared read bus quiet.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= rd_in ? rd_mux : 16'h0000;
        end
    end

    // The pin carries the one-hertz square wave when both bits allow.
    // Registering it keeps decode glitches off the pin.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_out_q <= 1'b0;
        end else begin
            clock_out_q <= clock_output_enable_q & run &
                           half_second_status;
        end
    end

    // Top outputs come straight from their flops.
    assign rd_data_out = rd_data_q;
    assign module_enable_out = clock_module_enable_q;
    assign clock_out = clock_out_q;

endmodule

//--- test/rtccfg_asserts.sv
// Purpose: Port-level checks of the configuration register block.
// Assumes: One clock domain; nrst_in is the only reset.
// Notes: A shadow of the writable fields predicts read-back values.
module rtccfg_asserts (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Register port.
    input wire logic [1:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rd_data_out,
    // Pins.
    input wire logic src_clk_in,
    input wire logic module_enable_out,
    input wire logic clock_out
);
    logic [15:0] sh_q;
    logic [15:0] sh_d;
    wire cfg_wr = wr_in && addr_in == rtccfg_pkg::ADDR_CFG;
    wire hi_acc = (wr_in || rd_in) && addr_in == rtccfg_pkg::ADDR_WIN_HIGH;
    wire [15:0] cfg_img = {sh_q[13] ? wr_data_in[15] : sh_q[15], 1'b0,
        wr_data_in[13], 2'b00, wr_data_in[10:0]};

    // Shadow: the enable bit follows only when unlocked, pointer steps down.
    assign sh_d = cfg_wr ? cfg_img :
        (hi_acc && sh_q[9:8] != 2'b00) ? sh_q - 16'h0100 : sh_q;

    // Shadow register, cleared with the design so both start alike.
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sh_q <= 16'h0000;
        end else begin
            sh_q <= sh_d;
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    rd_idle_zero_a: assert property (
        !rd_in |=> rd_data_out == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_in && addr_in == 2'h3
        |=> rd_data_out == 16'h0000) else $error("unmapped read not zero");
    cfg_readback_a: assert property (rd_in &&
        addr_in == rtccfg_pkg::ADDR_CFG
        |=> (rd_data_out & 16'he7ff) == $past(sh_q))
        else $error("config read-back mismatch");
    high_reserved_a: assert property (rd_in &&
        addr_in == rtccfg_pkg::ADDR_WIN_HIGH && sh_q[9:8] == 2'h3
        |=> rd_data_out == 16'h0000) else $error("reserved byte not zero");
    enable_on_a: assert property (sh_q[15] && $past(sh_q[15])
        |-> module_enable_out) else $error("module not enabled");
    enable_off_a: assert property (!sh_q[15] && !$past(sh_q[15])
        |-> !module_enable_out) else $error("module not disabled");
    output_gate_a: assert property (!module_enable_out &&
        !$past(module_enable_out) |-> !clock_out)
        else $error("clock output while module disabled");
    oe_gate_a: assert property (!sh_q[10] && !$past(sh_q[10])
        |-> !clock_out) else $error("clock output while output disabled");
endmodule

bind rtccfg_top rtccfg_asserts rtccfg_asserts_inst (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .src_clk_in(src_clk_in),
    .module_enable_out(module_enable_out), .clock_out(clock_out));

//--- test/test_rtccfg_top.sv
// Purpose: Self-checking bench of the configuration register block.
// Assumes: Source pin idles low; one test toggles it at the fastest rate.
// Notes: A full second of edges is too long to run, so bit 12 stays low.
module test_rtccfg_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [1:0] addr_in = 2'h0;
    logic [15:0] wr_data_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic src_clk_in = 1'b0;
    logic [15:0] rd_data_out;
    logic module_enable_out;
    logic clock_out;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] lo_v [4] = '{8'h30, 8'h21, 8'h15, 8'h98};
    logic [7:0] hi_v [4] = '{8'h45, 8'h04, 8'h11, 8'h00};
    localparam logic [1:0] CFG = rtccfg_pkg::ADDR_CFG;
    localparam logic [1:0] HI = rtccfg_pkg::ADDR_WIN_HIGH;
    localparam logic [1:0] LO = rtccfg_pkg::ADDR_WIN_LOW;
    localparam int HALF_PULSES = 1 << (rtccfg_pkg::PRE_BITS - 1);

    rtccfg_top rtccfg_top_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out), .src_clk_in(src_clk_in),
        .module_enable_out(module_enable_out), .clock_out(clock_out));

    // Clock of 5 ns period.
    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end

    // Compares one value and counts it.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    // One-cycle read; data are taken in the cycle after the strobe.
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp,
                          input logic [15:0] mask);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rd_data_out & mask, exp);
    endtask

    // Toggles the source pin, one rising edge every two clocks, then lets
    // the last edge pass the synchroniser and reach the prescaler.
    task automatic pulse_src(input int n);
        @(posedge mclk_in);
        repeat (n) begin
            src_clk_in <= 1'b1;
            @(posedge mclk_in);
            src_clk_in <= 1'b0;
            @(posedge mclk_in);
        end
        repeat (4) @(posedge mclk_in);
    endtask

    // Verdict, reached from the test sequence or the watchdog.
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog, well beyond half a second of edges and the register tests.
    initial begin
        repeat (60000) @(posedge mclk_in);
        error_cnt++;
        tally_and_finish();
    end

    // Test sequence.
    initial begin
        repeat (10) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd_chk(CFG, 16'h0000, 16'hffff);
        wr(CFG, 16'h8000);
        rd_chk(CFG, 16'h0000, 16'hffff);
        chk({15'h0, module_enable_out}, 16'h0000);
        $display("test reset_and_lock done");
        wr(CFG, 16'h2000);
        wr(CFG, 16'hffff);
        rd_chk(CFG, 16'ha7ff, 16'he7ff);
        chk({15'h0, module_enable_out}, 16'h0001);
        $display("test enable_unlocked done");
        // Fill all window fields, each pair but the last leaves the pointer one lower.
        for (int p = 3; p >= 0; p--) begin
            wr(LO, {8'h00, lo_v[p]});
            wr(HI, {8'h00, hi_v[p]});
        end
        rd_chk(CFG, 16'h0000, 16'h0300);
        wr(CFG, 16'ha700);
        for (int p = 3; p >= 0; p--) begin
            rd_chk(LO, {8'h00, lo_v[p]}, 16'h00ff);
            rd_chk(HI, {8'h00, hi_v[p]}, 16'h00ff);
            rd_chk(CFG, {6'h00, p == 0 ? 2'h0 : 2'(p - 1), 8'h00},
                16'h0300);
        end
        $display("test window_pointer done");
        // One source edge short of half a second, then the last one.
        pulse_src(HALF_PULSES - 1);
        rd_chk(CFG, 16'h0000, 16'h0800);
        pulse_src(1);
        rd_chk(CFG, 16'h0800, 16'h0800);
        chk({15'h0, clock_out}, 16'h0001);
        // Writing the seconds restarts the second; then read them twice.
        wr(LO, 16'h0030);
        rd_chk(CFG, 16'h0000, 16'h0800);
        chk({15'h0, clock_out}, 16'h0000);
        rd_chk(LO, 16'h0030, 16'h00ff);
        rd_chk(LO, 16'h0030, 16'h00ff);
        $display("test half_second done");
        wr(CFG, 16'h8300);
        wr(LO, 16'h0077);
        wr(HI, 16'h0077);
        rd_chk(CFG, 16'h8200, 16'he7ff);
        wr(LO, 16'h0077);
        wr(CFG, 16'h0300);
        rd_chk(CFG, 16'h8300, 16'he7ff);
        rd_chk(LO, 16'h0098, 16'h00ff);
        rd_chk(HI, 16'h0000, 16'h00ff);
        rd_chk(LO, 16'h0015, 16'h00ff);
        rd_chk(HI, 16'h0011, 16'h00ff);
        $display("test write_lock done");
        wr(2'h3, 16'hffff);
        rd_chk(2'h3, 16'h0000, 16'hffff);
        rd_chk(CFG, 16'h8100, 16'he7ff);
        chk({15'h0, clock_out}, 16'h0000);
        $display("test unmapped done");
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd_chk(CFG, 16'h0000, 16'hffff);
        chk({15'h0, module_enable_out}, 16'h0000);
        rd_chk(LO, 16'h0000, 16'h00ff);
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
